// ---- stmd_pkg.sv ----
// Constants shared by the standard timer operating-mode logic
package stmd_pkg;

  // ************************************************************
  // Register byte offsets
  // ************************************************************
  localparam logic [7:0] OFS_CTRL0 = 8'h00;
  localparam logic [7:0] OFS_CTRL1 = 8'h04;
  localparam logic [7:0] OFS_COUNT = 8'h08;
  localparam logic [7:0] OFS_CMPA  = 8'h0C;
  localparam logic [7:0] OFS_CMPP  = 8'h10;
  localparam logic [7:0] OFS_FLAGS = 8'h14;

  // ************************************************************
  // Field positions
  // ************************************************************
  localparam int CTRL0_CLK_LSB  = 4;   // clock select, 3 bits
  localparam int CTRL0_EN_BIT   = 3;   // counter_enable
  localparam int CTRL1_MODE_LSB = 6;   // mode_sel_hi/lo
  localparam int CTRL1_ACT_LSB  = 4;   // pin_action_hi/lo
  localparam int CTRL1_OIL_BIT  = 3;   // output_initial_level
  localparam int CTRL1_INV_BIT  = 2;   // output_invert
  localparam int CTRL1_SWAP_BIT = 1;   // duty_period_swap
  localparam int CTRL1_CLR_BIT  = 0;   // clear_select
  localparam int FLAG_A_BIT     = 0;   // cmp_a_flag
  localparam int FLAG_P_BIT     = 1;   // cmp_p_flag

  // ************************************************************
  // Reset values
  // ************************************************************
  localparam logic [7:0]  RST_CTRL  = 8'h00;
  localparam logic [15:0] RST_CMPA  = 16'h0000;
  localparam logic [7:0]  RST_CMPP  = 8'h00;
  localparam logic [15:0] RST_COUNT = 16'h0000;
  localparam logic [31:0] RST_RDATA = 32'h0000_0000;

  // ************************************************************
  // Modes, pin actions and clock sources
  // ************************************************************
  typedef enum logic [1:0] {
    STMD_MODE_CMP   = 2'b00,
    STMD_MODE_CAP   = 2'b01,
    STMD_MODE_PWM   = 2'b10,
    STMD_MODE_TIMER = 2'b11
  } stmd_mode_e;

  localparam logic [1:0] ACT_NONE   = 2'b00;  // compare: keep / pwm: inactive / cap: rise
  localparam logic [1:0] ACT_LOW    = 2'b01;  // compare: low  / pwm: active   / cap: fall
  localparam logic [1:0] ACT_HIGH   = 2'b10;  // compare: high / pwm: run      / cap: both
  localparam logic [1:0] ACT_TOGGLE = 2'b11;  // compare: toggle / single pulse / cap: off

  localparam logic [2:0] CLK_DIV4    = 3'b000;
  localparam logic [2:0] CLK_DIV1    = 3'b001;
  localparam logic [2:0] CLK_DIV16   = 3'b010;
  localparam logic [2:0] CLK_DIV64   = 3'b011;
  localparam logic [2:0] CLK_SLOW0   = 3'b100;
  localparam logic [2:0] CLK_SLOW1   = 3'b101;
  localparam logic [2:0] CLK_EXT_R   = 3'b110;
  localparam logic [2:0] CLK_EXT_F   = 3'b111;

  // ************************************************************
  // Prescaler terminal counts
  // ************************************************************
  localparam logic [7:0] DIV4_LAST  = 8'h03;
  localparam logic [7:0] DIV16_LAST = 8'h0F;
  localparam logic [7:0] DIV64_LAST = 8'h3F;
  localparam logic [7:0] SLOW_LAST  = 8'hFF;

endpackage

// ---- stmd_edge.sv ----
// Rising and falling edge detector for a synchronous pin
`timescale 1ns/1ps
module stmd_edge (
  // Clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // Pin and edges
  input  wire logic pin,
  output logic      rise,
  output logic      fall
);

  typedef struct packed {
    logic prev;
    logic rise;
    logic fall;
  } stmd_edge_s;

  stmd_edge_s s;
  stmd_edge_s next_s;

  always_comb begin
    next_s      = s;
    next_s.prev = pin;
    next_s.rise = pin & ~s.prev;
    next_s.fall = ~pin & s.prev;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign rise = s.rise;
  assign fall = s.fall;

endmodule // stmd_edge

// ---- stmd_prescale.sv ----
// Counter clock enable generator
`timescale 1ns/1ps
module stmd_prescale (
  // Clock and reset
  input  wire logic       pclk,
  input  wire logic       presetn,
  // Source selection
  input  wire logic [2:0] clk_sel,
  input  wire logic       ext_rise,
  input  wire logic       ext_fall,
  // Counter clock enable
  output logic            tick
);

  typedef struct packed {
    logic [7:0] div;
    logic       tick;
  } stmd_pre_s;

  stmd_pre_s s;
  stmd_pre_s next_s;

  always_comb begin
    next_s     = s;
    next_s.div = s.div + 8'h01;
    case (clk_sel)
      stmd_pkg::CLK_DIV4:  next_s.tick = (s.div[1:0] == stmd_pkg::DIV4_LAST[1:0]);
      stmd_pkg::CLK_DIV1:  next_s.tick = 1'b1;
      stmd_pkg::CLK_DIV16: next_s.tick = (s.div[3:0] == stmd_pkg::DIV16_LAST[3:0]);
      stmd_pkg::CLK_DIV64: next_s.tick = (s.div[5:0] == stmd_pkg::DIV64_LAST[5:0]);
      stmd_pkg::CLK_SLOW0,
      stmd_pkg::CLK_SLOW1: next_s.tick = (s.div == stmd_pkg::SLOW_LAST);
      stmd_pkg::CLK_EXT_R: next_s.tick = ext_rise;
      stmd_pkg::CLK_EXT_F: next_s.tick = ext_fall;
      default:             next_s.tick = 1'b0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign tick = s.tick;

endmodule // stmd_prescale

// ---- stmd_top.sv ----
// Standard timer operating modes with APB register access
`timescale 1ns/1ps
module stmd_top (
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // Pins
  input  wire logic        ext_clock_trigger_pin,
  input  wire logic        capture_input_pin,
  output logic             timer_output_pin,
  output logic             timer_output_en,
  // Status
  output logic             cmp_a_flag,
  output logic             cmp_p_flag
);

  // ************************************************************
  // State
  // ************************************************************
  typedef struct packed {
    logic        counter_enable;
    logic        en_q;
    logic [2:0]  clk_sel;
    logic [1:0]  mode;
    logic [1:0]  pin_action_field;
    logic        output_initial_level;
    logic        output_invert;
    logic        duty_period_swap;
    logic        clear_select;
    logic [15:0] compare_a_value;
    logic [7:0]  compare_p_value;
    logic [15:0] count;
    logic        cmp_a_flag;
    logic        cmp_p_flag;
    logic        pin_lvl;
    logic        pin_out;
    logic        pin_en;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } stmd_top_s;

  stmd_top_s s;
  stmd_top_s next_s;

  logic        tick;
  logic        ext_rise;
  logic        ext_fall;
  logic        cap_rise;
  logic        cap_fall;
  logic        start;
  logic        wr;
  logic        match_a;
  logic        a_end;
  logic        p_end;
  logic        is_single;
  logic        cap_edge;
  logic        below_duty;
  logic        pwm_active;
  logic [16:0] duty;
  logic [7:0]  p_less;

  // ************************************************************
  // Pin edges and counter clock enable
  // ************************************************************
  stmd_edge u_ext_edge (
    .pclk    (pclk),
    .presetn (presetn),
    .pin     (ext_clock_trigger_pin),
    .rise    (ext_rise),
    .fall    (ext_fall)
  );

  stmd_edge u_cap_edge (
    .pclk    (pclk),
    .presetn (presetn),
    .pin     (capture_input_pin),
    .rise    (cap_rise),
    .fall    (cap_fall)
  );

  stmd_prescale u_prescale (
    .pclk     (pclk),
    .presetn  (presetn),
    .clk_sel  (s.clk_sel),
    .ext_rise (ext_rise),
    .ext_fall (ext_fall),
    .tick     (tick)
  );

  // ************************************************************
  // Comparators and decode
  // ************************************************************
  assign start     = s.counter_enable & ~s.en_q;
  assign wr        = psel & penable & s.pready & pwrite;
  assign match_a   = (s.count == s.compare_a_value);
  assign a_end     = (s.count == (s.compare_a_value - 16'h0001));
  // P of zero wraps to all ones, so the period ends at overflow
  assign p_less    = s.compare_p_value - 8'h01;
  assign p_end     = (s.count == {p_less, 8'hFF});
  assign is_single = (s.mode == stmd_pkg::STMD_MODE_PWM) &&
                     (s.pin_action_field == stmd_pkg::ACT_TOGGLE);
  assign duty      = s.duty_period_swap ?
                     ((s.compare_p_value == 8'h00) ? 17'h1_0000 :
                      {1'b0, s.compare_p_value, 8'h00}) :
                     {1'b0, s.compare_a_value};
  // Duty at or beyond the period keeps the output active throughout
  assign below_duty = ({1'b0, s.count} < duty);

  always_comb begin
    case (s.pin_action_field)
      stmd_pkg::ACT_NONE: pwm_active = 1'b0;
      stmd_pkg::ACT_LOW:  pwm_active = 1'b1;
      stmd_pkg::ACT_HIGH: pwm_active = below_duty;
      default:            pwm_active = 1'b0;
    endcase
  end

  always_comb begin
    case (s.pin_action_field)
      stmd_pkg::ACT_NONE: cap_edge = cap_rise;
      stmd_pkg::ACT_LOW:  cap_edge = cap_fall;
      stmd_pkg::ACT_HIGH: cap_edge = cap_rise | cap_fall;
      default:            cap_edge = 1'b0;
    endcase
  end

  // ************************************************************
  // Next state
  // ************************************************************
  always_comb begin
    next_s         = s;
    next_s.en_q    = s.counter_enable;
    next_s.pready  = 1'b0;
    next_s.pslverr = 1'b0;

    // Setup cycle: read data and answer are prepared for the access phase
    if (psel && !penable) begin
      next_s.pready = 1'b1;
      next_s.prdata = stmd_pkg::RST_RDATA;
      case (paddr)
        stmd_pkg::OFS_CTRL0: begin
          next_s.prdata[stmd_pkg::CTRL0_CLK_LSB +: 3] = s.clk_sel;
          next_s.prdata[stmd_pkg::CTRL0_EN_BIT]       = s.counter_enable;
        end
        stmd_pkg::OFS_CTRL1: begin
          next_s.prdata[stmd_pkg::CTRL1_MODE_LSB +: 2] = s.mode;
          next_s.prdata[stmd_pkg::CTRL1_ACT_LSB +: 2]  = s.pin_action_field;
          next_s.prdata[stmd_pkg::CTRL1_OIL_BIT]       = s.output_initial_level;
          next_s.prdata[stmd_pkg::CTRL1_INV_BIT]       = s.output_invert;
          next_s.prdata[stmd_pkg::CTRL1_SWAP_BIT]      = s.duty_period_swap;
          next_s.prdata[stmd_pkg::CTRL1_CLR_BIT]       = s.clear_select;
        end
        stmd_pkg::OFS_COUNT: next_s.prdata[15:0] = s.count;
        stmd_pkg::OFS_CMPA:  next_s.prdata[15:0] = s.compare_a_value;
        stmd_pkg::OFS_CMPP:  next_s.prdata[7:0]  = s.compare_p_value;
        stmd_pkg::OFS_FLAGS: begin
          next_s.prdata[stmd_pkg::FLAG_A_BIT] = s.cmp_a_flag;
          next_s.prdata[stmd_pkg::FLAG_P_BIT] = s.cmp_p_flag;
        end
        default: next_s.pslverr = 1'b1;
      endcase
    end

    // Register writes take effect at the completing access edge
    if (wr) begin
      case (paddr)
        stmd_pkg::OFS_CTRL0: begin
          next_s.clk_sel        = pwdata[stmd_pkg::CTRL0_CLK_LSB +: 3];
          next_s.counter_enable = pwdata[stmd_pkg::CTRL0_EN_BIT];
        end
        stmd_pkg::OFS_CTRL1: begin
          next_s.mode                 = pwdata[stmd_pkg::CTRL1_MODE_LSB +: 2];
          next_s.pin_action_field     = pwdata[stmd_pkg::CTRL1_ACT_LSB +: 2];
          next_s.output_initial_level = pwdata[stmd_pkg::CTRL1_OIL_BIT];
          next_s.output_invert        = pwdata[stmd_pkg::CTRL1_INV_BIT];
          next_s.duty_period_swap     = pwdata[stmd_pkg::CTRL1_SWAP_BIT];
          next_s.clear_select         = pwdata[stmd_pkg::CTRL1_CLR_BIT];
        end
        stmd_pkg::OFS_CMPA: next_s.compare_a_value = pwdata[15:0];
        stmd_pkg::OFS_CMPP: next_s.compare_p_value = pwdata[7:0];
        stmd_pkg::OFS_FLAGS: begin
          if (pwdata[stmd_pkg::FLAG_A_BIT]) begin
            next_s.cmp_a_flag = 1'b0;
          end
          if (pwdata[stmd_pkg::FLAG_P_BIT]) begin
            next_s.cmp_p_flag = 1'b0;
          end
        end
        default: ;
      endcase
    end

    // Hardware events below override software writes in the same cycle
    if (is_single && !s.counter_enable && ext_rise) begin
      next_s.counter_enable = 1'b1;
    end

    if (start) begin
      next_s.count = stmd_pkg::RST_COUNT;
      if (s.mode == stmd_pkg::STMD_MODE_CMP) begin
        next_s.pin_lvl = s.output_initial_level;
      end
    end else if (s.counter_enable && tick) begin
      next_s.count = s.count + 16'h0001;
      case (s.mode)
        stmd_pkg::STMD_MODE_CMP,
        stmd_pkg::STMD_MODE_TIMER: begin
          if (match_a) begin
            next_s.cmp_a_flag = 1'b1;
            if (s.mode == stmd_pkg::STMD_MODE_CMP) begin
              case (s.pin_action_field)
                stmd_pkg::ACT_LOW:    next_s.pin_lvl = 1'b0;
                stmd_pkg::ACT_HIGH:   next_s.pin_lvl = 1'b1;
                stmd_pkg::ACT_TOGGLE: next_s.pin_lvl = ~s.pin_lvl;
                default:              next_s.pin_lvl = s.pin_lvl;
              endcase
            end
          end
          if (s.clear_select) begin
            if (match_a) begin
              next_s.count = stmd_pkg::RST_COUNT;
            end
          end else if (p_end) begin
            next_s.count      = stmd_pkg::RST_COUNT;
            next_s.cmp_p_flag = 1'b1;
          end
        end
        stmd_pkg::STMD_MODE_PWM: begin
          if (is_single) begin
            if (match_a) begin
              next_s.counter_enable = 1'b0;
              next_s.cmp_a_flag     = 1'b1;
            end
          end else begin
            if (s.duty_period_swap ? a_end : match_a) begin
              next_s.cmp_a_flag = 1'b1;
            end
            if (p_end) begin
              next_s.cmp_p_flag = 1'b1;
            end
            if (s.duty_period_swap ? a_end : p_end) begin
              next_s.count = stmd_pkg::RST_COUNT;
            end
          end
        end
        stmd_pkg::STMD_MODE_CAP: begin
          if (p_end) begin
            next_s.count      = stmd_pkg::RST_COUNT;
            next_s.cmp_p_flag = 1'b1;
          end
        end
        default: ;
      endcase
    end

    if (s.mode == stmd_pkg::STMD_MODE_CAP && s.counter_enable && cap_edge) begin
      next_s.compare_a_value = s.count;
      next_s.cmp_a_flag      = 1'b1;
    end

    // Waveform modes drive the level from the running count or enable
    if (s.mode == stmd_pkg::STMD_MODE_PWM) begin
      if (is_single) begin
        next_s.pin_lvl = next_s.counter_enable ? s.output_initial_level
                                               : ~s.output_initial_level;
      end else begin
        next_s.pin_lvl = pwm_active ? s.output_initial_level
                                    : ~s.output_initial_level;
      end
    end

    next_s.pin_out = next_s.pin_lvl ^ next_s.output_invert;
    next_s.pin_en  = (next_s.mode == stmd_pkg::STMD_MODE_CMP) ||
                     (next_s.mode == stmd_pkg::STMD_MODE_PWM);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  // ************************************************************
  // Outputs
  // ************************************************************
  assign prdata           = s.prdata;
  assign pready           = s.pready;
  assign pslverr          = s.pslverr;
  assign timer_output_pin = s.pin_out;
  assign timer_output_en  = s.pin_en;
  assign cmp_a_flag       = s.cmp_a_flag;
  assign cmp_p_flag       = s.cmp_p_flag;

  // ************************************************************
  // Assertions
  // ************************************************************
  enable_rise_zero_a: assert property (@(posedge pclk) disable iff (!presetn)
    start |=> (s.count == 16'h0000))
    else $error("counter not zeroed after enable rise");

  initial_level_a: assert property (@(posedge pclk) disable iff (!presetn)
    (start && s.mode == stmd_pkg::STMD_MODE_CMP) |=>
      (s.pin_lvl == $past(s.output_initial_level)))
    else $error("pin not loaded with initial level");

  pin_only_a_a: assert property (@(posedge pclk) disable iff (!presetn)
    (s.mode == stmd_pkg::STMD_MODE_CMP && !start &&
     !(s.counter_enable && tick && match_a)) |=> $stable(s.pin_lvl))
    else $error("pin moved without comparator A match");

  no_p_flag_a: assert property (@(posedge pclk) disable iff (!presetn)
    (s.mode == stmd_pkg::STMD_MODE_CMP && s.clear_select && !s.cmp_p_flag) |=>
      !s.cmp_p_flag)
    else $error("P flag raised with clear-select set");

  p_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
    (s.mode inside {stmd_pkg::STMD_MODE_CMP, stmd_pkg::STMD_MODE_TIMER} && !s.clear_select &&
     s.counter_enable && tick && !start && p_end) |=> (s.count == 16'h0000 && s.cmp_p_flag))
    else $error("P match did not clear counter and flag");

  pulse_end_a: assert property (@(posedge pclk) disable iff (!presetn)
    (is_single && s.counter_enable && tick && !start && match_a) |=>
      (!s.counter_enable && s.cmp_a_flag &&
       s.pin_lvl == !$past(s.output_initial_level)))
    else $error("single pulse did not end on A match");

  capture_copy_a: assert property (@(posedge pclk) disable iff (!presetn)
    (s.mode == stmd_pkg::STMD_MODE_CAP && s.counter_enable && cap_edge) |=>
      (s.compare_a_value == $past(s.count) && s.cmp_a_flag))
    else $error("capture did not copy the counter");

  flag_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
    (s.cmp_a_flag && !(wr && paddr == stmd_pkg::OFS_FLAGS &&
     pwdata[stmd_pkg::FLAG_A_BIT])) |=> s.cmp_a_flag)
    else $error("A flag dropped without software clear");

endmodule // stmd_top

// ---- stmd_far_model.sv ----
// Far-side pin driver: external trigger/clock pin and capture input pin
`timescale 1ns/1ps
module stmd_far_model (
  // Clock
  input  wire logic pclk,
  // Pins toward the timer
  output logic      ext_clock_trigger_pin,
  output logic      capture_input_pin
);
  initial begin
    ext_clock_trigger_pin = 1'b0;
    capture_input_pin     = 1'b0;
  end

  // Capture input level, changed just after an edge
  task automatic set_capture(input logic lvl);
    @(posedge pclk);
    capture_input_pin <= lvl;
  endtask

  // One active (rising) edge on the trigger pin, held long enough to be seen
  task automatic fire_trigger();
    @(posedge pclk);
    ext_clock_trigger_pin <= 1'b1;
    repeat (4) @(posedge pclk);
    ext_clock_trigger_pin <= 1'b0;
  endtask
endmodule // stmd_far_model

// ---- tb_standard_timer_operating_modes.sv ----
// Self-checking bench for the standard timer operating modes over APB
`timescale 1ns/1ps
module tb_standard_timer_operating_modes;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]  paddr  = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata, r;
  logic        pready, pslverr, ext_pin, cap_pin, pin, pin_en, flag_a, flag_p, e, bad;
  int          n_mismatch = 0, checks = 0, hi = 0;

  always #4 pclk = ~pclk;

  stmd_top DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .ext_clock_trigger_pin(ext_pin), .capture_input_pin(cap_pin),
    .timer_output_pin(pin), .timer_output_en(pin_en), .cmp_a_flag(flag_a),
    .cmp_p_flag(flag_p));
  stmd_far_model FAR (.pclk(pclk), .ext_clock_trigger_pin(ext_pin),
    .capture_input_pin(cap_pin));

  // ************************************************************
  // Bus cycles and comparisons
  // ************************************************************
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t word got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_bit(input logic got, input logic exp);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t bit got %b expected %b", $time, got, exp);
    end
  endtask
  task automatic wait_a(input int n);
    repeat (n) begin
      @(posedge pclk);
      if (flag_a === 1'b1) break;
    end
    repeat (2) @(posedge pclk);
  endtask
  // High cycles of the output pin over a window of n clocks
  task automatic count_high(input int n, output int cnt);
    cnt = 0;
    repeat (n) begin
      @(posedge pclk);
      if (pin === 1'b1) cnt++;
    end
  endtask
  task automatic restart(input logic [7:0] ctrl1);
    wr(stmd_pkg::OFS_CTRL0, 32'h0000_0010);
    wr(stmd_pkg::OFS_FLAGS, 32'h0000_0003);
    wr(stmd_pkg::OFS_CTRL1, {24'h00_0000, ctrl1});
    wr(stmd_pkg::OFS_CTRL0, 32'h0000_0018);
    repeat (3) @(posedge pclk);
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  initial begin
    #200000;
    n_mismatch++;
    tally_and_finish();
  end

  // ************************************************************
  // Tests
  // ************************************************************
  initial begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, stmd_pkg::OFS_CTRL1, 32'h0);
    chk_word(r, 32'h0000_0000);
    apb(1'b0, 8'h18, 32'h0);
    chk_word(r, 32'h0000_0000);
    chk_bit(e, 1'b1);
    wr(stmd_pkg::OFS_CMPP, 32'h0000_01FF);
    apb(1'b0, stmd_pkg::OFS_CMPP, 32'h0);
    chk_word(r, 32'h0000_00FF);
    $display("test registers done");
    wr(stmd_pkg::OFS_CMPA, 32'h0000_0040);
    restart(8'h38);
    chk_bit(pin, 1'b1);
    wait_a(200);
    chk_bit(pin, 1'b0);
    chk_bit(flag_p, 1'b0);
    repeat (20) @(posedge pclk);
    apb(1'b0, stmd_pkg::OFS_FLAGS, 32'h0);
    chk_word(r, 32'h0000_0001);
    wr(stmd_pkg::OFS_CTRL1, 32'h0000_003C);
    repeat (3) @(posedge pclk);
    chk_bit(pin, 1'b1);
    $display("test compare output done");
    wr(stmd_pkg::OFS_CMPP, 32'h0000_0001);
    wr(stmd_pkg::OFS_CMPA, 32'h0000_0200);
    restart(8'h09);
    repeat (700) @(posedge pclk);
    chk_bit(flag_a, 1'b1);
    chk_bit(flag_p, 1'b0);
    chk_bit(pin, 1'b1);
    wr(stmd_pkg::OFS_CMPA, 32'h0000_0010);
    restart(8'hC0);
    repeat (300) @(posedge pclk);
    chk_bit(flag_a, 1'b1);
    chk_bit(flag_p, 1'b1);
    chk_bit(pin_en, 1'b0);
    $display("test clear select done");
    wr(stmd_pkg::OFS_CMPP, 32'h0000_0000);
    wr(stmd_pkg::OFS_CMPA, 32'h0000_ABCD);
    for (int act = 0; act < 4; act++) begin
      restart({2'b01, act[1:0], 4'h0});
      FAR.set_capture(1'b1);
      repeat (6) @(posedge pclk);
      chk_bit(flag_a, act == 0 || act == 2);
      FAR.set_capture(1'b0);
      repeat (6) @(posedge pclk);
      chk_bit(flag_a, act != 3);
      apb(1'b0, stmd_pkg::OFS_CMPA, 32'h0);
      chk_bit(r[15:0] < 16'h0100, act != 3);
      wr(stmd_pkg::OFS_CMPA, 32'h0000_ABCD);
    end
    $display("test capture done");
    wr(stmd_pkg::OFS_CMPP, 32'h0000_0001);
    wr(stmd_pkg::OFS_CMPA, 32'h0000_0200);
    restart(8'h98);
    chk_bit(pin, 1'b1);
    restart(8'h88);
    chk_bit(pin, 1'b0);
    restart(8'hA8);
    bad = 1'b0;
    repeat (300) begin
      @(posedge pclk);
      if (pin !== 1'b1 || pin_en !== 1'b1) bad = 1'b1;
    end
    chk_bit(bad, 1'b0);
    chk_bit(flag_p, 1'b1);
    wr(stmd_pkg::OFS_CMPA, 32'h0000_0040);
    restart(8'hA8);
    count_high(256, hi);
    chk_word(hi, 32'h0000_0040);
    wr(stmd_pkg::OFS_CMPA, 32'h0000_0180);
    restart(8'hAA);
    count_high(384, hi);
    chk_word(hi, 32'h0000_0100);
    chk_bit(flag_a, 1'b1);
    $display("test pwm done");
    wr(stmd_pkg::OFS_CMPA, 32'h0000_0020);
    restart(8'hB8);
    wr(stmd_pkg::OFS_CTRL0, 32'h0000_0010);
    wr(stmd_pkg::OFS_FLAGS, 32'h0000_0003);
    repeat (3) @(posedge pclk);
    chk_bit(pin, 1'b0);
    FAR.fire_trigger();
    chk_bit(pin, 1'b1);
    wait_a(100);
    chk_bit(pin, 1'b0);
    apb(1'b0, stmd_pkg::OFS_CTRL0, 32'h0);
    chk_word(r, 32'h0000_0010);
    $display("test single pulse done");
    tally_and_finish();
  end
endmodule // tb_standard_timer_operating_modes
